// ==== rtl/hbm_framer.sv ====
// HDLC framer and deframer with slot bit masking and AXI4-Lite registers
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "hbm_map.svh"
module hbm_framer
	import hbm_pkg::*;
#(
	parameter int TX_DEPTH = 64,
	parameter int RX_DEPTH = 64
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic tclk,
	input wire logic rclk,
	input wire logic fs,
	input wire logic rxd,
	output logic txd_o,
	output logic txd_oe
);
	localparam int TAW = $clog2(TX_DEPTH);
	localparam int RAW = $clog2(RX_DEPTH);

	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic b);
		logic fb;
		fb = c[15] ^ b;
		return {c[14:0], 1'b0} ^ (fb ? `HBM_CRC_POLY : 16'h0000);
	endfunction

	// Mask bit for the current bit time in the chosen serial order
	function automatic logic mask_pick(input logic [7:0] m,
		input logic [2:0] i, input logic msb);
		return msb ? m[3'd7 - i] : m[i];
	endfunction

	function automatic logic [15:0] rev16(input logic [15:0] v);
		logic [15:0] r;
		for (int k = 0; k < 16; k++)
			r[k] = v[15 - k];
		return r;
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		return a == `HBM_A_CTRL || a == `HBM_A_TXDATA
			|| a == `HBM_A_TXTAG || a == `HBM_A_RXDATA
			|| a == `HBM_A_STATUS || a == `HBM_A_RXMASK
			|| a == `HBM_A_TXMASK;
	endfunction

	// ****************************************
	// Synchronisers and link clock edges
	// ****************************************
	logic [2:0] tclk_s_q, rclk_s_q, fs_s_q;
	logic [1:0] rxd_s_q;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tclk_s_q <= '0;
			rclk_s_q <= '0;
			fs_s_q <= '0;
			rxd_s_q <= '0;
		end
		else
		begin
			tclk_s_q <= {tclk_s_q[1:0], tclk};
			rclk_s_q <= {rclk_s_q[1:0], rclk};
			fs_s_q <= {fs_s_q[1:0], fs};
			rxd_s_q <= {rxd_s_q[0], rxd};
		end
	end
	// Transmit on falling edge, sample on rising edge of the data clocks
	wire tx_edge = tclk_s_q[2] && !tclk_s_q[1];
	wire rx_edge = rclk_s_q[1] && !rclk_s_q[2];
	wire fs_rise = fs_s_q[1] && !fs_s_q[2];
	wire rxb = rxd_s_q[1];

	// ****************************************
	// Register bus slave
	// ****************************************
	logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q;
	logic arready_q, rvalid_q, berr_q, rerr_q;
	logic [7:0] awaddr_q, wbyte_q;
	logic wlane_q;
	logic [31:0] rdata_q, rd_mux;
	logic [7:0] ctrl_q, rx_mask_q, tx_mask_q;
	logic idle_q;
	wire aw_take = s_axi_awvalid && awready_q;
	wire w_take = s_axi_wvalid && wready_q;
	wire ar_take = s_axi_arvalid && arready_q;
	wire wr_do = aw_have_q && w_have_q;
	wire w_ok = wr_do && wlane_q;
	wire w_ctrl = w_ok && awaddr_q == `HBM_A_CTRL;
	wire w_txd = w_ok && awaddr_q == `HBM_A_TXDATA;
	wire w_tag = w_ok && awaddr_q == `HBM_A_TXTAG;
	wire w_stat = w_ok && awaddr_q == `HBM_A_STATUS;
	wire w_rxm = w_ok && awaddr_q == `HBM_A_RXMASK;
	wire w_txm = w_ok && awaddr_q == `HBM_A_TXMASK;
	wire r_pop_sel = ar_take && s_axi_araddr == `HBM_A_RXDATA;
	wire bvalid_d = wr_do || (bvalid_q && !s_axi_bready);
	wire rvalid_d = ar_take || (rvalid_q && !s_axi_rready);
	wire aw_have_d = (aw_have_q || aw_take) && !wr_do;
	wire w_have_d = (w_have_q || w_take) && !wr_do;
	wire hwy = ctrl_q[`HBM_B_HWY];

	// Handshake state; each channel held until its own ready
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			berr_q <= 1'b0;
			rerr_q <= 1'b0;
			awaddr_q <= 8'h00;
			wbyte_q <= 8'h00;
			wlane_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awready_q <= !aw_have_d && !bvalid_d;
			wready_q <= !w_have_d && !bvalid_d;
			bvalid_q <= bvalid_d;
			arready_q <= !rvalid_d;
			rvalid_q <= rvalid_d;
			if (aw_take)
				awaddr_q <= s_axi_awaddr;
			if (w_take)
			begin
				wbyte_q <= s_axi_wdata[7:0];
				wlane_q <= s_axi_wstrb[0];
			end
			if (wr_do)
				berr_q <= !addr_ok(awaddr_q);
			if (ar_take)
			begin
				rdata_q <= rd_mux;
				rerr_q <= !addr_ok(s_axi_araddr);
			end
		end
	end
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = berr_q ? `HBM_RESP_ERR : `HBM_RESP_OK;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rerr_q ? `HBM_RESP_ERR : `HBM_RESP_OK;

	// ****************************************
	// Transmit FIFO
	// ****************************************
	logic [TAW:0] tx_wp_q, tx_rp_q;
	logic [7:0] last_byte_q;
	logic [1:0] last_tag_q;
	logic tx_seen_q, tx_pop;
	logic [9:0] tx_head;
	wire tx_empty = tx_wp_q == tx_rp_q;
	wire tx_full = (tx_wp_q ^ tx_rp_q) == {1'b1, {TAW{1'b0}}};
	wire tx_push = w_txd && !tx_full;
	// Tag rewrites the newest entry; old tags are ORed so none is cleared
	wire [1:0] tag_new = last_tag_q | {wbyte_q[`HBM_B_ABT], wbyte_q[`HBM_B_FC]};
	wire tag_we = w_tag && !tx_empty;
	wire [TAW-1:0] tx_wa = tx_push ? tx_wp_q[TAW-1:0] : tx_wp_q[TAW-1:0] - 1'b1;
	wire [9:0] tx_wd = tx_push ? {2'b00, wbyte_q} : {tag_new, last_byte_q};
	// Head is usable one cycle after it appears, once the read port caught up
	wire tx_avail = tx_seen_q && !tx_empty;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_wp_q <= '0;
			tx_rp_q <= '0;
			last_byte_q <= 8'h00;
			last_tag_q <= 2'b00;
			tx_seen_q <= 1'b0;
		end
		else
		begin
			tx_seen_q <= !tx_empty;
			if (tx_push)
			begin
				tx_wp_q <= tx_wp_q + 1'b1;
				last_byte_q <= wbyte_q;
				last_tag_q <= 2'b00;
			end
			else if (tag_we)
				last_tag_q <= tag_new;
			if (tx_pop)
				tx_rp_q <= tx_rp_q + 1'b1;
		end
	end
	hbm_ram #(.W(10), .DEPTH(TX_DEPTH), .AW(TAW)) u_tx_ram
	(
		.clk(mclk),
		.rst_n(rst_n),
		.we(tx_push || tag_we),
		.waddr(tx_wa),
		.wdata(tx_wd),
		.raddr(tx_rp_q[TAW-1:0]),
		.rdata(tx_head)
	);

	// ****************************************
	// Transmitter
	// ****************************************
	hbm_tx_state_type st_q, st_d;
	logic [15:0] sh_q, sh_d, crc_q;
	logic [4:0] cnt_q, cnt_d;
	logic [2:0] ones_q, tidx_q;
	logic fc_q, fc_d, txd_q, oe_q;
	wire tx_bit_on = !hwy || mask_pick(tx_mask_q, tidx_q, ctrl_q[`HBM_B_TXORD]);
	wire tx_tick = tx_edge && tx_bit_on;
	wire stuffing = st_q == HBM_ST_DATA || st_q == HBM_ST_CRC;
	// Count grows only in stuffed fields, so a run of five that ends the
	// check sequence still gets its zero ahead of the closing flag
	wire stuff_now = ones_q == 3'd5;
	wire bit_out = stuff_now ? 1'b0 : sh_q[0];
	wire tx_load = tx_tick && !stuff_now && cnt_q == 5'd1;
	wire [15:0] crc_upd = crc_step(crc_q, bit_out);
	wire [7:0] fill_byte = ctrl_q[`HBM_B_FILL] ? `HBM_FLAG : `HBM_ONES;

	// Next byte to shift once the current one has gone out
	always_comb
	begin
		st_d = HBM_ST_FILL;
		sh_d = {8'h00, fill_byte};
		cnt_d = 5'd8;
		fc_d = 1'b0;
		tx_pop = 1'b0;
		case (st_q)
			HBM_ST_FILL, HBM_ST_CLOSE:
				if (ctrl_q[`HBM_B_TXEN] && tx_avail)
				begin
					st_d = HBM_ST_OPEN;
					sh_d = {8'h00, `HBM_FLAG};
				end
			HBM_ST_OPEN, HBM_ST_DATA:
				if (st_q == HBM_ST_DATA && fc_q)
				begin
					st_d = HBM_ST_CRC;
					sh_d = rev16(~crc_upd);
					cnt_d = 5'd16;
				end
				else if (tx_avail && !tx_head[9])
				begin
					st_d = HBM_ST_DATA;
					sh_d = {8'h00, tx_head[7:0]};
					fc_d = tx_head[8];
					tx_pop = tx_load;
				end
				else
				begin
					// Abort tag or underrun both send the abort pattern
					sh_d = {8'h00, `HBM_ABORT};
					tx_pop = tx_load && tx_avail;
				end
			HBM_ST_CRC:
			begin
				st_d = HBM_ST_CLOSE;
				sh_d = {8'h00, `HBM_FLAG};
			end
			default:
				st_d = HBM_ST_FILL;
		endcase
	end

	// Bit shifter; check sequence runs over unstuffed data bits only
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= HBM_ST_FILL;
			sh_q <= {8'h00, `HBM_ONES};
			cnt_q <= 5'd8;
			ones_q <= 3'd0;
			fc_q <= 1'b0;
			crc_q <= `HBM_CRC_INIT;
			txd_q <= 1'b1;
			oe_q <= 1'b0;
			tidx_q <= 3'd0;
		end
		else
		begin
			if (tx_edge)
			begin
				oe_q <= tx_bit_on;
				tidx_q <= fs_rise ? 3'd1 : tidx_q + 3'd1;
			end
			else if (fs_rise)
				tidx_q <= 3'd0;
			if (tx_tick)
			begin
				txd_q <= bit_out;
				if (stuff_now || !stuffing || !bit_out)
					ones_q <= 3'd0;
				else
					ones_q <= ones_q + 3'd1;
				if (st_q == HBM_ST_DATA && !stuff_now)
					crc_q <= crc_upd;
				if (!stuff_now)
				begin
					sh_q <= {1'b0, sh_q[15:1]};
					cnt_q <= cnt_q - 5'd1;
				end
				if (st_q == HBM_ST_OPEN)
					crc_q <= `HBM_CRC_INIT;
				if (tx_load)
				begin
					st_q <= st_d;
					sh_q <= sh_d;
					cnt_q <= cnt_d;
					fc_q <= fc_d;
				end
			end
		end
	end
	assign txd_o = txd_q;
	assign txd_oe = oe_q;

	// ****************************************
	// Receiver
	// ****************************************
	logic [2:0] ridx_q;
	logic [3:0] rones_q;
	logic [6:0] pipe_q, pv_q;
	logic [7:0] asm_q, hb0_q, hb1_q;
	logic [2:0] bc_q;
	logic [1:0] hn_q;
	logic [15:0] rcrc_q;
	logic in_frame_q, got_q, ovr_q;
	wire rx_acc = rx_edge && ctrl_q[`HBM_B_RXEN]
		&& (!hwy || mask_pick(rx_mask_q, ridx_q, ctrl_q[`HBM_B_RXORD]));
	wire flag_ev = rx_acc && !rxb && rones_q == 4'd6;
	wire stuff_ev = rx_acc && !rxb && rones_q == 4'd5 && in_frame_q;
	wire seven_ev = rx_acc && rxb && rones_q == 4'd6;
	wire abort_ev = seven_ev && in_frame_q && got_q;
	wire idle_ev = rx_acc && rxb && rones_q == 4'd14;
	wire shift_ev = rx_acc && !flag_ev && !stuff_ev;
	wire commit = shift_ev && pv_q[0];
	wire byte_ev = commit && bc_q == 3'd7;
	wire [7:0] new_byte = {pipe_q[0], asm_q[7:1]};
	wire [15:0] rcrc_upd = crc_step(rcrc_q, pipe_q[0]);
	wire close_ev = flag_ev && in_frame_q && got_q;
	wire [7:0] sf_byte = {rcrc_q != `HBM_CRC_GOOD, abort_ev, ovr_q,
		bc_q != 3'd0, 4'h0};
	logic [RAW:0] rx_wp_q, rx_rp_q;
	logic [8:0] rx_head;
	wire rx_empty = rx_wp_q == rx_rp_q;
	// Read port lags a fresh write by a cycle, so report valid one later
	logic rx_seen_q;
	wire rx_avail = rx_seen_q && !rx_empty;
	wire rx_full = (rx_wp_q ^ rx_rp_q) == {1'b1, {RAW{1'b0}}};
	// Oldest held byte leaves once two newer ones stand behind it
	wire data_push = byte_ev && hn_q == 2'd2;
	wire stat_push = close_ev || abort_ev;
	wire rx_push = (data_push || stat_push) && !rx_full;
	wire [8:0] rx_wd = stat_push ? {1'b1, sf_byte} : {1'b0, hb0_q};
	wire rx_pop = r_pop_sel && rx_avail;

	// Deframer; seven-bit delay line lets a delimiter be taken back out
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ridx_q <= 3'd0;
			rones_q <= 4'd0;
			pipe_q <= 7'h00;
			pv_q <= 7'h00;
			asm_q <= 8'h00;
			hb0_q <= 8'h00;
			hb1_q <= 8'h00;
			bc_q <= 3'd0;
			hn_q <= 2'd0;
			rcrc_q <= `HBM_CRC_INIT;
			in_frame_q <= 1'b0;
			got_q <= 1'b0;
			ovr_q <= 1'b0;
		end
		else
		begin
			if (rx_edge)
				ridx_q <= fs_rise ? 3'd1 : ridx_q + 3'd1;
			else if (fs_rise)
				ridx_q <= 3'd0;
			if (rx_acc)
				rones_q <= !rxb ? 4'd0
					: (rones_q == 4'd15 ? rones_q : rones_q + 4'd1);
			if (shift_ev)
			begin
				pipe_q <= {rxb, pipe_q[6:1]};
				pv_q <= {in_frame_q, pv_q[6:1]};
			end
			if (commit)
			begin
				asm_q <= new_byte;
				bc_q <= bc_q + 3'd1;
				rcrc_q <= rcrc_upd;
				got_q <= 1'b1;
			end
			if (byte_ev)
			begin
				hb1_q <= new_byte;
				hb0_q <= hn_q == 2'd0 ? new_byte : hb1_q;
				if (hn_q != 2'd2)
					hn_q <= hn_q + 2'd1;
			end
			if ((data_push || stat_push) && rx_full)
				ovr_q <= 1'b1;
			else if (stat_push)
				ovr_q <= 1'b0;
			// Held bytes are the check sequence and are dropped here
			if (flag_ev || seven_ev)
			begin
				pv_q <= 7'h00;
				hn_q <= 2'd0;
				bc_q <= 3'd0;
				got_q <= 1'b0;
				rcrc_q <= `HBM_CRC_INIT;
				in_frame_q <= flag_ev;
			end
		end
	end
	hbm_ram #(.W(9), .DEPTH(RX_DEPTH), .AW(RAW)) u_rx_ram
	(
		.clk(mclk),
		.rst_n(rst_n),
		.we(rx_push),
		.waddr(rx_wp_q[RAW-1:0]),
		.wdata(rx_wd),
		.raddr(rx_rp_q[RAW-1:0]),
		.rdata(rx_head)
	);

	// ****************************************
	// Control registers and read mux
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_q <= `HBM_CTRL_RST;
			rx_mask_q <= `HBM_RXMASK_RST;
			tx_mask_q <= `HBM_TXMASK_RST;
			idle_q <= 1'b0;
			rx_wp_q <= '0;
			rx_rp_q <= '0;
			rx_seen_q <= 1'b0;
		end
		else
		begin
			if (w_ctrl)
				ctrl_q <= wbyte_q;
			if (w_rxm)
				rx_mask_q <= wbyte_q;
			if (w_txm)
				tx_mask_q <= wbyte_q;
			// Set beats a simultaneous write-one-to-clear
			idle_q <= idle_ev || (idle_q
				&& !(w_stat && wbyte_q[`HBM_B_IDLE]));
			if (rx_push)
				rx_wp_q <= rx_wp_q + 1'b1;
			if (rx_pop)
				rx_rp_q <= rx_rp_q + 1'b1;
			rx_seen_q <= !rx_empty;
		end
	end

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (s_axi_araddr == `HBM_A_CTRL)
			rd_mux[7:0] = ctrl_q;
		else if (s_axi_araddr == `HBM_A_RXDATA)
			rd_mux[9:0] = {rx_avail, rx_avail ? rx_head : 9'h000};
		else if (s_axi_araddr == `HBM_A_STATUS)
			rd_mux[7:0] = {1'b0, idle_q, 2'b00, rx_full, rx_empty,
				tx_full, tx_empty};
		else if (s_axi_araddr == `HBM_A_RXMASK)
			rd_mux[7:0] = rx_mask_q;
		else if (s_axi_araddr == `HBM_A_TXMASK)
			rd_mux[7:0] = tx_mask_q;
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_rx_mask;
		(rx_edge && hwy && !mask_pick(rx_mask_q, ridx_q,
			ctrl_q[`HBM_B_RXORD])) |-> !rx_acc;
	endproperty
	a_rx_mask: assert property (p_rx_mask) else $error("masked rx bit used");
	property p_tx_hiz;
		(tx_edge && hwy && !tx_bit_on) |=> !txd_oe ##1 !txd_oe[*1];
	endproperty
	a_tx_hiz: assert property (p_tx_hiz) else $error("masked bit driven");
	property p_tx_reset_mask;
		(tx_mask_q == 8'h00 && hwy && tx_edge) |=> !txd_oe;
	endproperty
	a_tx_reset_mask: assert property (p_tx_reset_mask) else $error("tx leak");
	property p_stuff;
		(tx_tick && stuff_now) |=> (!txd_o && ones_q == 3'd0);
	endproperty
	a_stuff: assert property (p_stuff) else $error("no stuffed zero");
	property p_open_flag;
		(tx_load && st_d == HBM_ST_OPEN) |=> sh_q == {8'h00, `HBM_FLAG};
	endproperty
	a_open_flag: assert property (p_open_flag) else $error("bad flag");
	property p_crc_len;
		(tx_load && st_d == HBM_ST_CRC) |=> cnt_q == 5'd16 && st_q == HBM_ST_CRC;
	endproperty
	a_crc_len: assert property (p_crc_len) else $error("crc length");
	property p_destuff;
		stuff_ev |=> $stable(pipe_q) && $stable(pv_q);
	endproperty
	a_destuff: assert property (p_destuff) else $error("stuff kept");
	property p_idle;
		idle_ev |=> idle_q [*2];
	endproperty
	a_idle: assert property (p_idle) else $error("idle not set");
	property p_abort;
		abort_ev |-> ##1 (!in_frame_q && hn_q == 2'd0);
	endproperty
	a_abort: assert property (p_abort) else $error("abort not handled");
	property p_abort_sf;
		(abort_ev && !rx_full) |-> rx_push && rx_wd[6] && rx_wd[8];
	endproperty
	a_abort_sf: assert property (p_abort_sf) else $error("no abort status");
	c_close: cover property (close_ev);
	c_abort: cover property (abort_ev);
	c_crc: cover property (tx_load && st_d == HBM_ST_CRC);
	c_idle: cover property (idle_ev);
endmodule
`default_nettype wire

// ==== rtl/hbm_ram.sv ====
// Small memory of 10-bit or 9-bit words with registered read data, used for both FIFOs
`timescale 1ns/1ps
`default_nettype none
module hbm_ram
#(
	parameter int W = 10,
	parameter int DEPTH = 64,
	parameter int AW = 6
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output var logic [W-1:0] rdata
);
	logic [W-1:0] mem [DEPTH];

	// Array has no reset so it maps onto plain storage
	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
	end

	// Read port is registered every cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata <= '0;
		else
			rdata <= mem[raddr];
	end
endmodule
`default_nettype wire

// ==== shared/hbm_map.svh ====
// Register offsets, field positions, reset values and patterns of the framer
`ifndef HBM_MAP_SVH
`define HBM_MAP_SVH
`define HBM_A_CTRL 8'h00
`define HBM_A_TXDATA 8'h04
`define HBM_A_TXTAG 8'h08
`define HBM_A_RXDATA 8'h0C
`define HBM_A_STATUS 8'h10
`define HBM_A_RXMASK 8'h14
`define HBM_A_TXMASK 8'h18
`define HBM_B_TXEN 0
`define HBM_B_RXEN 1
`define HBM_B_FILL 2
`define HBM_B_TXORD 3
`define HBM_B_RXORD 4
`define HBM_B_HWY 7
`define HBM_B_FC 7
`define HBM_B_ABT 6
`define HBM_B_IDLE 6
`define HBM_CTRL_RST 8'h00
`define HBM_RXMASK_RST 8'hFF
`define HBM_TXMASK_RST 8'h00
`define HBM_FLAG 8'h7E
`define HBM_ONES 8'hFF
`define HBM_ABORT 8'hFE
`define HBM_CRC_POLY 16'h1021
`define HBM_CRC_INIT 16'hFFFF
`define HBM_CRC_GOOD 16'h1D0F
`define HBM_RESP_OK 2'b00
`define HBM_RESP_ERR 2'b10
`endif

// ==== shared/hbm_pkg.sv ====
// Types shared by the framer design
package hbm_pkg;
	typedef enum logic [2:0]
	{
		HBM_ST_FILL = 3'b000,
		HBM_ST_OPEN = 3'b001,
		HBM_ST_DATA = 3'b010,
		HBM_ST_CRC = 3'b011,
		HBM_ST_CLOSE = 3'b100
	} hbm_tx_state_type;
endpackage

// ==== test/hbm_line_model.sv ====
// Line-side partner: highway clock, frame sync, pulled-up data line
`timescale 1ns/1ps
`default_nettype none
module hbm_line_model
(
	input wire logic txd_o,
	input wire logic txd_oe,
	output logic tclk,
	output logic rclk,
	output logic fs,
	output logic rxd,
	output logic [23:0] hist,
	output logic [3:0] low_last
);
	logic [2:0] idx;
	logic [3:0] low_cnt;
	// ****
	// Line level
	// ****
	// A released line floats high through the pull-up, then echoes back
	assign rxd = txd_oe ? txd_o : 1'b1;
	assign rclk = tclk;
	// Highway clock runs free, in a phase unrelated to the system clock
	initial
	begin
		tclk = 1'b0;
		idx = 3'd0;
		fs = 1'b0;
		low_cnt = 4'h0;
		low_last = 4'h0;
		hist = 24'h00_0000;
		#137;
		forever #200 tclk = ~tclk;
	end
	// One sync bit in eight, moved on the falling edge
	always @(negedge tclk)
	begin
		idx <= idx + 3'd1;
		fs <= (idx == 3'd7);
	end
	// Capture bits; eight-bit window always spans one whole slot of mask
	always @(posedge tclk)
	begin
		hist <= {rxd, hist[23:1]};
		if (idx == 3'd0)
		begin
			low_last <= low_cnt;
			low_cnt <= {3'b000, ~txd_oe};
		end
		else
			low_cnt <= low_cnt + {3'b000, ~txd_oe};
	end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench: registers, fill, loopback frames, bit masks
`timescale 1ns/1ps
`default_nettype none
`include "hbm_map.svh"
module tb;
	// ****
	// Signals
	// ****
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] aw_a = 8'h00;
	logic [7:0] ar_a = 8'h00;
	logic [31:0] w_d = 32'h0000_0000;
	logic aw_v = 1'b0, w_v = 1'b0, ar_v = 1'b0;
	logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, tclk, rclk, fs, rxd;
	logic txd_o, txd_oe;
	logic [1:0] b_resp, r_resp, resp;
	logic [31:0] r_d, d;
	logic [23:0] hist;
	logic [3:0] low_last;
	logic [7:0] frm [5] = '{8'hFF, 8'h7E, 8'h3E, 8'h81, 8'hF8};
	int mismatches = 0;
	int checks_done = 0;
	always #25 mclk = ~mclk;
	// Ready lines stay high: the bench never stalls a response
	hbm_framer #(.TX_DEPTH(8), .RX_DEPTH(8)) u_hbm_framer
	(
		.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(aw_a),
		.s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy),
		.s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(1'b1),
		.s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
		.s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
		.s_axi_rready(1'b1), .tclk(tclk), .rclk(rclk), .fs(fs), .rxd(rxd),
		.txd_o(txd_o), .txd_oe(txd_oe)
	);
	hbm_line_model u_hbm_line_model
	(
		.txd_o(txd_o), .txd_oe(txd_oe), .tclk(tclk), .rclk(rclk), .fs(fs),
		.rxd(rxd), .hist(hist), .low_last(low_last)
	);
	// ****
	// Tasks
	// ****
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		aw_a <= a;
		w_d <= {24'h00_0000, v};
		aw_v <= 1'b1;
		w_v <= 1'b1;
		for (int n = 0; n < 200; n++)
		begin
			@(posedge mclk);
			if (aw_rdy)
				aw_v <= 1'b0;
			if (w_rdy)
				w_v <= 1'b0;
			if (b_v)
				break;
		end
		resp = b_resp;
	endtask
	task automatic rd(input logic [7:0] a);
		ar_a <= a;
		ar_v <= 1'b1;
		for (int n = 0; n < 200; n++)
		begin
			@(posedge mclk);
			if (ar_rdy)
				ar_v <= 1'b0;
			if (r_v)
				break;
		end
		d = r_d;
		resp = r_resp;
	endtask
	// Polls the receive queue; a read pops only when an entry is valid, so empty reads are skipped
	task automatic rx_expect(input logic [9:0] e, input logic [9:0] m);
		for (int n = 0; n < 3000; n++)
		begin
			rd(`HBM_A_RXDATA);
			if (d[9] === 1'b1)
				break;
		end
		chk("rx entry", {22'h0, e}, d & {22'h0, m});
	endtask
	task automatic send(input logic [7:0] b, input logic [7:0] tag);
		wr(`HBM_A_TXDATA, b);
		if (tag !== 8'h00)
			wr(`HBM_A_TXTAG, tag);
	endtask
	task automatic bits(input int n);
		repeat (n) @(posedge tclk);
		@(posedge mclk);
	endtask
	function automatic logic flag_pair(input logic [23:0] h);
		flag_pair = 1'b0;
		for (int i = 0; i < 8; i++)
			if (h[i+:16] == 16'h7E7E)
				flag_pair = 1'b1;
	endfunction
	task automatic print_verdict();
		if (mismatches == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ****
	// Tests
	// ****
	// Watchdog: far beyond the longest expected run
	initial
	begin
		#5000000;
		mismatches++;
		print_verdict();
	end
	initial
	begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		rd(`HBM_A_CTRL);
		chk("ctrl", 32'h0000_0000, d);
		rd(`HBM_A_RXMASK);
		chk("rx mask", 32'h0000_00FF, d);
		rd(`HBM_A_TXMASK);
		chk("tx mask", 32'h0000_0000, d);
		rd(8'h1C);
		chk("read resp", {30'h0, `HBM_RESP_ERR}, {30'h0, resp});
		wr(8'h1C, 8'hFF);
		chk("write resp", {30'h0, `HBM_RESP_ERR}, {30'h0, resp});
		// Ones fill; masks have no say outside highway mode
		wr(`HBM_A_CTRL, 8'h03);
		bits(40);
		chk("ones fill", 32'h00FF_FFFF, {8'h00, hist});
		chk("undriven bits", 32'h0, {28'h000_0000, low_last});
		rd(`HBM_A_STATUS);
		chk("idle status", 32'h0000_0040, d & 32'h0000_0040);
		wr(`HBM_A_CTRL, 8'h07);
		bits(40);
		chk("flag fill", 32'h1, {31'h0, flag_pair(hist)});
		// Flags never make fifteen ones, so the cleared bit stays clear
		wr(`HBM_A_STATUS, 8'h40);
		rd(`HBM_A_STATUS);
		chk("idle cleared", 32'h0, d & 32'h0000_0040);
		// Two frames queued back to back, awkward stuffing bytes
		foreach (frm[i])
			send(frm[i], (i == 2 || i == 4) ? 8'h80 : 8'h00);
		foreach (frm[i])
		begin
			rx_expect({2'b10, frm[i]}, 10'h3FF);
			if (i == 2 || i == 4)
				rx_expect(10'h300, 10'h3FF);
		end
		// Dummy bytes first so the abort never lands on the first byte
		send(8'h55, 8'h00);
		send(8'hAA, 8'h00);
		send(8'h12, 8'h40);
		wr(`HBM_A_TXTAG, 8'h00);
		rx_expect(10'h340, 10'h340);
		send(8'h42, 8'h00);
		send(8'h24, 8'h80);
		rx_expect(10'h242, 10'h3FF);
		rx_expect(10'h224, 10'h3FF);
		rx_expect(10'h300, 10'h3FF);
		// Highway mode: transmit mask gates the output enable
		wr(`HBM_A_CTRL, 8'h87);
		bits(24);
		chk("masked bits", 32'h8, {28'h000_0000, low_last});
		wr(`HBM_A_TXMASK, 8'h0F);
		rd(`HBM_A_TXMASK);
		chk("tx mask", 32'h0000_000F, d);
		bits(24);
		chk("masked bits", 32'h4, {28'h000_0000, low_last});
		wr(`HBM_A_TXMASK, 8'hFF);
		wr(`HBM_A_RXMASK, 8'h00);
		send(8'h5A, 8'h00);
		send(8'hA5, 8'h80);
		bits(200);
		rd(`HBM_A_RXDATA);
		chk("masked rx", 32'h0, d & 32'h0000_0200);
		wr(`HBM_A_RXMASK, 8'hFF);
		send(8'h33, 8'h00);
		send(8'hCC, 8'h80);
		rx_expect(10'h233, 10'h3FF);
		rx_expect(10'h2CC, 10'h3FF);
		rx_expect(10'h300, 10'h3FF);
		print_verdict();
	end
endmodule
`default_nettype wire
